// File: pkg/bkc_pkg.sv
/*
  Shared constants for the breakpoint control block: register indices,
  field positions, reset values and the break sequencing states.
  Assumes byte addresses on the register bus are four times an index.
*/
package bkc_pkg;

  // Register bus geometry
  localparam int BKC_ADDR_W = 10;
  localparam int BKC_DATA_W = 32;

  // Register indices (byte address is four times the index)
  localparam logic [7:0] BKC_CTRL_TWO_IDX = 8'h28;
  localparam logic [7:0] BKC_CTRL_THREE_IDX = 8'h29;
  localparam logic [7:0] BKC_TRACE_CTRL_IDX = 8'h2A;
  localparam logic [7:0] BKC_IRQ_STATUS_IDX = 8'h2B;
  localparam logic [7:0] BKC_IRQ_MASK_IDX = 8'h2C;

  // Control two fields
  localparam int BKC_PAIR_EN_BIT = 7;
  localparam int BKC_ADDR_DATA_BIT = 6;
  localparam int BKC_BGND_SEL_BIT = 5;
  localparam int BKC_PAIR_TAG_BIT = 4;
  localparam int BKC_C_EN_BIT = 3;
  localparam int BKC_C_TAG_BIT = 2;
  localparam int BKC_C_RWEN_BIT = 1;
  localparam int BKC_C_RWVAL_BIT = 0;

  // Control three fields
  localparam int BKC_A_MASK_HI_BIT = 7;
  localparam int BKC_A_MASK_LO_BIT = 6;
  localparam int BKC_B_MASK_HI_BIT = 5;
  localparam int BKC_B_MASK_LO_BIT = 4;
  localparam int BKC_A_RWEN_BIT = 3;
  localparam int BKC_A_RWVAL_BIT = 2;
  localparam int BKC_B_RWEN_BIT = 1;
  localparam int BKC_B_RWVAL_BIT = 0;

  // Trace control fields
  localparam int BKC_TRACE_EN_BIT = 0;
  localparam int BKC_SINGLE_LOOP_CAPTURE_BIT = 1;
  localparam int BKC_ARM_BIT = 2;

  // Interrupt status fields
  localparam int BKC_IRQ_BREAK_BIT = 0;
  localparam int BKC_IRQ_CANCEL_BIT = 1;
  localparam int BKC_IRQ_W = 2;

  // Reset values
  localparam logic [7:0] BKC_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] BKC_CTRL_THREE_RST = 8'h00;
  localparam logic [1:0] BKC_TRACE_CTRL_RST = 2'h0;
  localparam logic [1:0] BKC_IRQ_RST = 2'h0;

  // Bus answer latency in cycles after the access phase begins
  localparam int BKC_BUS_WAIT_CYCLES = 1;

  // Break sequencing states
  typedef enum logic [1:0] {
    BKC_IDLE,
    BKC_TAG_WAIT,
    BKC_REQUEST
  } bkc_state_t;

endpackage

// File: logic/bkc_breakpoint_ctrl.sv
/*
  Breakpoint control registers of an on-chip debug module with an APB
  slave, break sequencing towards the CPU core and an interrupt output.
  Assumes the comparator datapaths, the core's tag reporting and
  break_taken all run on pclk; comparator matches are single-cycle
  level inputs valid in the cycle they are asserted.
*/
// How it works
// - Pair enable turns A/B on, blocks trace enable
// - Mode bit picks dual-address or address-plus-data
// - Destination bit picks soft interrupt or background
// - Pair tag bit picks forced or tagged break
// - Tagged break dropped when opcode not executed
// - Third enable; cleared when armed in single_loop_capture
// - Third tag bit picks forced or tagged break
// - Third direction qualify enable joins the match
// - Third direction value: 0 write, 1 read
// - Pair bits ignored while pair break off, except mode for trace B masks
// - Third breakpoint works unless trace single_loop_capture capture
// - Trace mode forces comparator A masks zero
// - Trace mode B masks only in address-data
// - Control two at index 0x28, resets zero
// - Control three at index 0x29, fields, resets zero
// - A mask high-only case compares all lines
// - Comparator A direction qualify enable
`timescale 1ns/10ps
module bkc_breakpoint_ctrl (
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bkc_pkg::BKC_ADDR_W-1:0] paddr,
  input wire logic [bkc_pkg::BKC_DATA_W-1:0] pwdata,
  output logic [bkc_pkg::BKC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator match results and bus direction
  input wire logic comp_a_match,
  input wire logic comp_b_match,
  input wire logic comp_c_match,
  input wire logic bus_read,
  // Core tag reporting and break acknowledge
  input wire logic tag_execute,
  input wire logic tag_discard,
  input wire logic break_taken,
  // Break request to the core
  output logic break_req,
  output logic background_entry_select,
  output logic tag_pair,
  output logic tag_third,
  // Effective comparator settings to the match datapath
  output logic addr_data_mode,
  output logic [1:0] comp_a_mask_eff,
  output logic [1:0] comp_b_mask_eff,
  output logic trace_enable,
  // Interrupt
  output logic irq
);
  import bkc_pkg::*;

  // Byte address of a register index
  function automatic logic [BKC_ADDR_W-1:0] addr_of(input logic [7:0] idx);
    addr_of = {idx, 2'b00};
  endfunction

  // Direction qualifier: pass when disabled or direction agrees
  function automatic logic rw_ok(input logic en, input logic val, input logic rd);
    rw_ok = !en || (val == rd);
  endfunction

  logic [7:0] ctrl_two_reg, ctrl_two_next;
  logic [7:0] ctrl_three_reg, ctrl_three_next;
  logic [1:0] trace_ctrl_reg, trace_ctrl_next;
  logic [BKC_IRQ_W-1:0] irq_status_reg, irq_status_next;
  logic [BKC_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [BKC_DATA_W-1:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  bkc_state_t state_reg, state_next;
  logic break_req_reg, break_req_next;
  logic bgnd_reg, bgnd_next;
  logic [1:0] amask_reg, amask_next;
  logic [1:0] bmask_reg, bmask_next;
  logic adm_reg, adm_next;
  logic tag_pair_reg, tag_pair_next;
  logic tag_third_reg, tag_third_next;
  logic irq_reg, irq_next;

  logic wr_en, rd_en, hit_two, hit_three, hit_trace, hit_stat, hit_mask, mapped;
  logic trace_on, single_loop_capture_on, arm_single_loop_capture;
  logic pair_on, a_q, b_q, c_q, pair_hit, third_hit, third_active;
  logic force_hit, tag_hit, ev_break, ev_cancel;

  // Bus decode; answer comes in the second access cycle
  assign wr_en = psel && penable && pwrite && !pready_reg;
  assign rd_en = psel && penable && !pwrite && !pready_reg;
  assign hit_two = (paddr == addr_of(BKC_CTRL_TWO_IDX));
  assign hit_three = (paddr == addr_of(BKC_CTRL_THREE_IDX));
  assign hit_trace = (paddr == addr_of(BKC_TRACE_CTRL_IDX));
  assign hit_stat = (paddr == addr_of(BKC_IRQ_STATUS_IDX));
  assign hit_mask = (paddr == addr_of(BKC_IRQ_MASK_IDX));
  assign mapped = hit_two || hit_three || hit_trace || hit_stat || hit_mask;

  // Mode view of the stored controls
  assign trace_on = trace_ctrl_reg[BKC_TRACE_EN_BIT];
  assign single_loop_capture_on = trace_ctrl_reg[BKC_SINGLE_LOOP_CAPTURE_BIT];
  assign pair_on = ctrl_two_reg[BKC_PAIR_EN_BIT];
  assign arm_single_loop_capture = wr_en && hit_trace && pwdata[BKC_ARM_BIT] && pwdata[BKC_SINGLE_LOOP_CAPTURE_BIT];

  // Direction qualified comparator results
  assign a_q = comp_a_match && rw_ok(ctrl_three_reg[BKC_A_RWEN_BIT],
    ctrl_three_reg[BKC_A_RWVAL_BIT], bus_read);
  assign b_q = comp_b_match && rw_ok(ctrl_three_reg[BKC_B_RWEN_BIT],
    ctrl_three_reg[BKC_B_RWVAL_BIT], bus_read);
  assign c_q = comp_c_match && rw_ok(ctrl_two_reg[BKC_C_RWEN_BIT],
    ctrl_two_reg[BKC_C_RWVAL_BIT], bus_read);

  // Pair hit: both in address-data mode, either in dual mode
  assign pair_hit = pair_on && (ctrl_two_reg[BKC_ADDR_DATA_BIT] ?
    (a_q && b_q) : (a_q || b_q));
  // Third comparator, idle during trace single_loop_capture capture
  assign third_active = ctrl_two_reg[BKC_C_EN_BIT] && !(trace_on && single_loop_capture_on);
  assign third_hit = third_active && c_q;

  // Split hits by timing
  assign force_hit = (pair_hit && !ctrl_two_reg[BKC_PAIR_TAG_BIT]) ||
    (third_hit && !ctrl_two_reg[BKC_C_TAG_BIT]);
  assign tag_hit = (pair_hit && ctrl_two_reg[BKC_PAIR_TAG_BIT]) ||
    (third_hit && ctrl_two_reg[BKC_C_TAG_BIT]);

  // Register file next values
  always_comb begin
    ctrl_two_next = ctrl_two_reg;
    ctrl_three_next = ctrl_three_reg;
    trace_ctrl_next = trace_ctrl_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_en && hit_two) begin
      ctrl_two_next = pwdata[7:0];
    end
    if (wr_en && hit_three) begin
      ctrl_three_next = pwdata[7:0];
    end
    if (wr_en && hit_trace) begin
      trace_ctrl_next[BKC_SINGLE_LOOP_CAPTURE_BIT] = pwdata[BKC_SINGLE_LOOP_CAPTURE_BIT];
      trace_ctrl_next[BKC_TRACE_EN_BIT] = pwdata[BKC_TRACE_EN_BIT] && !pair_on;
    end
    if (wr_en && hit_mask) begin
      irq_mask_next = pwdata[BKC_IRQ_W-1:0];
    end
    if (arm_single_loop_capture) begin
      ctrl_two_next[BKC_C_EN_BIT] = 1'b0;
    end
    if (trace_ctrl_next[BKC_TRACE_EN_BIT]) begin
      ctrl_three_next[BKC_A_MASK_HI_BIT] = 1'b0;
      ctrl_three_next[BKC_A_MASK_LO_BIT] = 1'b0;
    end
  end

  // Register file storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_two_reg <= BKC_CTRL_TWO_RST;
      ctrl_three_reg <= BKC_CTRL_THREE_RST;
      trace_ctrl_reg <= BKC_TRACE_CTRL_RST;
      irq_mask_reg <= BKC_IRQ_RST;
    end else if (clk_en) begin
      ctrl_two_reg <= ctrl_two_next;
      ctrl_three_reg <= ctrl_three_next;
      trace_ctrl_reg <= trace_ctrl_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Bus answer: ready, read data and error for unmapped addresses
  always_comb begin
    pready_next = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !mapped;
    prdata_next = '0;
    if (rd_en) begin
      if (hit_two) begin
        prdata_next[7:0] = ctrl_two_reg;
      end else if (hit_three) begin
        prdata_next[7:0] = ctrl_three_reg;
      end else if (hit_trace) begin
        prdata_next[1:0] = trace_ctrl_reg;
      end else if (hit_stat) begin
        prdata_next[BKC_IRQ_W-1:0] = irq_status_reg;
      end else if (hit_mask) begin
        prdata_next[BKC_IRQ_W-1:0] = irq_mask_reg;
      end
    end
  end

  // Bus answer storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (clk_en) begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Break sequencing: forced hits request at once, tags wait for execution
  always_comb begin
    state_next = state_reg;
    bgnd_next = bgnd_reg;
    ev_break = 1'b0;
    ev_cancel = 1'b0;
    case (state_reg)
      BKC_IDLE: begin
        if (force_hit) begin
          state_next = BKC_REQUEST;
          bgnd_next = ctrl_two_reg[BKC_BGND_SEL_BIT];
          ev_break = 1'b1;
        end else if (tag_hit) begin
          state_next = BKC_TAG_WAIT;
        end
      end
      BKC_TAG_WAIT: begin
        if (tag_discard) begin
          state_next = BKC_IDLE;
          ev_cancel = 1'b1;
        end else if (tag_execute) begin
          state_next = BKC_REQUEST;
          bgnd_next = ctrl_two_reg[BKC_BGND_SEL_BIT];
          ev_break = 1'b1;
        end
      end
      BKC_REQUEST: begin
        if (break_taken) begin
          state_next = BKC_IDLE;
        end
      end
      default: begin
        state_next = BKC_IDLE;
      end
    endcase
    // Request output kept in its own flop
    break_req_next = (state_next == BKC_REQUEST);
  end

  // Break sequencing storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= BKC_IDLE;
      bgnd_reg <= 1'b0;
      break_req_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      bgnd_reg <= bgnd_next;
      break_req_reg <= break_req_next;
    end
  end

  // Effective comparator settings; tags flag a tagged comparator to the core
  always_comb begin
    adm_next = pair_on && ctrl_two_reg[BKC_ADDR_DATA_BIT];
    tag_pair_next = pair_on && ctrl_two_reg[BKC_PAIR_TAG_BIT];
    tag_third_next = third_active && ctrl_two_reg[BKC_C_TAG_BIT];
    amask_next = {ctrl_three_reg[BKC_A_MASK_HI_BIT], ctrl_three_reg[BKC_A_MASK_LO_BIT]};
    bmask_next = {ctrl_three_reg[BKC_B_MASK_HI_BIT], ctrl_three_reg[BKC_B_MASK_LO_BIT]};
    if (trace_on || (amask_next == 2'b10)) begin
      amask_next = 2'b00;
    end
    if (bmask_next == 2'b10) begin
      bmask_next = 2'b00;
    end
    if (trace_on && !ctrl_two_reg[BKC_ADDR_DATA_BIT]) begin
      bmask_next = 2'b00;
    end
  end

  // Effective settings storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adm_reg <= 1'b0;
      tag_pair_reg <= 1'b0;
      tag_third_reg <= 1'b0;
      amask_reg <= 2'b00;
      bmask_reg <= 2'b00;
    end else if (clk_en) begin
      adm_reg <= adm_next;
      tag_pair_reg <= tag_pair_next;
      tag_third_reg <= tag_third_next;
      amask_reg <= amask_next;
      bmask_reg <= bmask_next;
    end
  end

  // Sticky status, write one to clear, a new event wins over the clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_en && hit_stat) begin
      irq_status_next = irq_status_reg & ~pwdata[BKC_IRQ_W-1:0];
    end
    if (ev_break) begin
      irq_status_next[BKC_IRQ_BREAK_BIT] = 1'b1;
    end
    if (ev_cancel) begin
      irq_status_next[BKC_IRQ_CANCEL_BIT] = 1'b1;
    end
    irq_next = |(irq_status_next & irq_mask_next);
  end

  // Interrupt storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= BKC_IRQ_RST;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_status_reg <= irq_status_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign break_req = break_req_reg;
  assign background_entry_select = bgnd_reg;
  assign tag_pair = tag_pair_reg;
  assign tag_third = tag_third_reg;
  assign addr_data_mode = adm_reg;
  assign comp_a_mask_eff = amask_reg;
  assign comp_b_mask_eff = bmask_reg;
  assign trace_enable = trace_ctrl_reg[BKC_TRACE_EN_BIT];
  assign irq = irq_reg;

  // Checks
  property p_trace_blocked;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && pair_on) |=> !($rose(trace_ctrl_reg[BKC_TRACE_EN_BIT]));
  endproperty
  a_trace_blocked: assert property (p_trace_blocked)
    else $error("trace enable set while pair break on");

  property p_force_break;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && state_reg == BKC_IDLE && force_hit) |=> break_req;
  endproperty
  a_force_break: assert property (p_force_break)
    else $error("forced hit did not raise break request");

  property p_dest_latched;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && state_reg == BKC_IDLE && force_hit)
      |=> (bgnd_reg == $past(ctrl_two_reg[BKC_BGND_SEL_BIT]));
  endproperty
  a_dest_latched: assert property (p_dest_latched)
    else $error("break destination not taken from control");

  property p_discard_no_break;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && state_reg == BKC_TAG_WAIT && tag_discard) |=> !break_req;
  endproperty
  a_discard_no_break: assert property (p_discard_no_break)
    else $error("tagged break fired for discarded opcode");

  property p_single_loop_capture_clears;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && arm_single_loop_capture) |=> !ctrl_two_reg[BKC_C_EN_BIT];
  endproperty
  a_single_loop_capture_clears: assert property (p_single_loop_capture_clears)
    else $error("third enable kept after single_loop_capture arm");

  property p_amask_trace;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && trace_on) |=> (comp_a_mask_eff == 2'b00);
  endproperty
  a_amask_trace: assert property (p_amask_trace)
    else $error("comparator A mask live in trace mode");

  property p_pair_off;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !pair_on) |=> (!addr_data_mode && !tag_pair);
  endproperty
  a_pair_off: assert property (p_pair_off)
    else $error("pair settings active while pair break off");

  property p_ack_ends;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && break_req && break_taken) |=> !break_req;
  endproperty
  a_ack_ends: assert property (p_ack_ends)
    else $error("break request held after core took it");

  property p_readback;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && hit_three && !trace_on && !arm_single_loop_capture
      && !ctrl_two_reg[BKC_PAIR_EN_BIT])
      |=> (ctrl_three_reg == ($past(pwdata[7:0]) & ~(trace_on ? 8'hC0 : 8'h00)));
  endproperty
  a_readback: assert property (p_readback)
    else $error("control three did not store written value");

  property p_third_rw;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && state_reg == BKC_IDLE && ctrl_two_reg[BKC_C_RWEN_BIT] && !pair_on
      && ctrl_two_reg[BKC_C_RWVAL_BIT] != bus_read) |=> !break_req;
  endproperty
  a_third_rw: assert property (p_third_rw)
    else $error("third comparator matched wrong direction");

  property p_a_mask_hi_only;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl_three_reg[7:6] == 2'b10) |=> (comp_a_mask_eff == 2'b00);
  endproperty
  a_a_mask_hi_only: assert property (p_a_mask_hi_only)
    else $error("A high-only mask not forced to full compare");

endmodule

// File: tb/bkc_core_model.sv
/*
  Behavioural model of the CPU core that takes break requests.
  Assumes it shares pclk and presetn with the breakpoint block.
*/
`timescale 1ns/10ps
module bkc_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pace select, 1 for a slow core
  input wire logic slow,
  // Break handshake
  input wire logic break_req,
  input wire logic background_entry_select,
  output logic break_taken,
  output logic last_sel
);
  logic [3:0] wait_cnt;

  // Take a request after a short or long boundary wait, one pulse each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      break_taken <= 1'b0;
      last_sel <= 1'b0;
    end else begin
      break_taken <= 1'b0;
      if (break_req && !break_taken) begin
        if (wait_cnt >= (slow ? 4'h6 : 4'h0)) begin
          break_taken <= 1'b1;
          last_sel <= background_entry_select;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

// File: tb/test_breakpoint_control_regs.sv
/*
  Self-checking bench for the breakpoint control block.
  Assumes an APB master here and the core model on the break side.
*/
`timescale 1ns/10ps
module test_breakpoint_control_regs;
  import bkc_pkg::*;
  localparam logic [9:0] A_TWO = {BKC_CTRL_TWO_IDX, 2'b00};
  localparam logic [9:0] A_THREE = {BKC_CTRL_THREE_IDX, 2'b00};
  localparam logic [9:0] A_TRACE = {BKC_TRACE_CTRL_IDX, 2'b00};
  localparam logic [9:0] A_STAT = {BKC_IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] A_MASK = {BKC_IRQ_MASK_IDX, 2'b00};
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic comp_a_match, comp_b_match, comp_c_match, bus_read;
  logic tag_execute, tag_discard, break_taken, break_req, background_entry_select;
  logic tag_pair, tag_third, addr_data_mode, trace_enable, irq, slow, last_sel, seen;
  logic [1:0] comp_a_mask_eff, comp_b_mask_eff;
  int n_errors, n_checks;

  // Device under test
  bkc_breakpoint_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_a_match(comp_a_match),
    .comp_b_match(comp_b_match), .comp_c_match(comp_c_match), .bus_read(bus_read),
    .tag_execute(tag_execute), .tag_discard(tag_discard), .break_taken(break_taken),
    .break_req(break_req), .background_entry_select(background_entry_select),
    .tag_pair(tag_pair), .tag_third(tag_third), .addr_data_mode(addr_data_mode),
    .comp_a_mask_eff(comp_a_mask_eff), .comp_b_mask_eff(comp_b_mask_eff),
    .trace_enable(trace_enable), .irq(irq));

  // Core on the far side
  bkc_core_model i_core (.pclk(pclk), .presetn(presetn), .slow(slow), .break_req(break_req),
    .background_entry_select(background_entry_select), .break_taken(break_taken),
    .last_sel(last_sel));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(k < 20, "no bus answer");
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (2) @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(e === exp_err, "bus error flag");
    if (!exp_err) chk(r === {24'h0, exp}, "read data");
  endtask

  // Watch for a break request and let the core take it
  task automatic wait_break(input logic exp);
    int k;
    seen = 1'b0;
    for (k = 0; k < 4; k++) begin
      @(negedge pclk);
      if (break_req === 1'b1) seen = 1'b1;
    end
    chk(seen === exp, "break request");
    k = 0;
    while (break_req !== 1'b0 && k < 20) begin
      @(negedge pclk);
      k++;
    end
  endtask

  task automatic hit(input logic a, b, c, rd, exp);
    @(posedge pclk);
    comp_a_match <= a;
    comp_b_match <= b;
    comp_c_match <= c;
    bus_read <= rd;
    @(posedge pclk);
    {comp_a_match, comp_b_match, comp_c_match} <= 3'b000;
    wait_break(exp);
  endtask

  task automatic tag(input logic ex, input logic ds, input logic exp);
    @(posedge pclk);
    tag_execute <= ex;
    tag_discard <= ds;
    @(posedge pclk);
    tag_execute <= 1'b0;
    tag_discard <= 1'b0;
    wait_break(exp);
  endtask

  task automatic t_regs();
    rd_chk(A_TWO, 8'h00, 1'b0);
    rd_chk(A_THREE, 8'h00, 1'b0);
    rd_chk(10'h3FC, 8'h00, 1'b1);
    wr(A_TWO, 8'h7F);
    rd_chk(A_TWO, 8'h7F, 1'b0);
    chk(addr_data_mode === 1'b0 && tag_pair === 1'b0, "pair bits live");
    wr(A_THREE, 8'h3F);
    rd_chk(A_THREE, 8'h3F, 1'b0);
    wr(A_TWO, 8'hC0);
    chk(addr_data_mode === 1'b1, "address-data mode");
    wr(A_TRACE, 8'h01);
    chk(trace_enable === 1'b0, "trace set under pair");
    wr(A_THREE, 8'h80);
    chk(comp_a_mask_eff === 2'b00, "high-only mask");
    wr(A_THREE, 8'hC0);
    chk(comp_a_mask_eff === 2'b11, "both masks");
    $display("test regs done");
  endtask

  task automatic t_pair();
    hit(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    hit(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    wr(A_TWO, 8'h80);
    hit(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    wr(A_THREE, 8'h0C);
    hit(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    hit(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(A_THREE, 8'h00);
    wr(A_TWO, 8'h00);
    hit(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(A_TWO, 8'h90);
    chk(tag_pair === 1'b1, "pair tag out");
    hit(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    tag(1'b1, 1'b0, 1'b1);
    $display("test pair done");
  endtask

  task automatic t_dest();
    logic s;
    for (int i = 0; i < 2; i++) begin
      s = i[0];
      @(posedge pclk);
      slow <= s;
      wr(A_TWO, {2'b00, s, 5'b01000});
      hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      chk(last_sel === s, "destination select");
      rd_chk(A_STAT, 8'h01, 1'b0);
      chk(irq === 1'b0, "irq while masked");
      wr(A_MASK, 8'h01);
      chk(irq === 1'b1, "irq unmasked");
      wr(A_STAT, 8'h01);
      chk(irq === 1'b0, "irq after clear");
      wr(A_MASK, 8'h00);
    end
    $display("test destination done");
  endtask

  task automatic t_third();
    wr(A_TWO, 8'h0C);
    chk(tag_third === 1'b1, "third tag out");
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    tag(1'b0, 1'b1, 1'b0);
    tag(1'b1, 1'b0, 1'b0);
    rd_chk(A_STAT, 8'h02, 1'b0);
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    tag(1'b1, 1'b1, 1'b0);
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    tag(1'b1, 1'b0, 1'b1);
    wr(A_STAT, 8'h03);
    wr(A_TWO, 8'h0B);
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    hit(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    wr(A_TWO, 8'h0A);
    hit(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(A_TWO, 8'h09);
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    $display("test third done");
  endtask

  task automatic t_trace();
    wr(A_TWO, 8'h08);
    wr(A_TRACE, 8'h01);
    chk(trace_enable === 1'b1, "trace enable");
    wr(A_THREE, 8'hF5);
    rd_chk(A_THREE, 8'h35, 1'b0);
    chk(comp_a_mask_eff === 2'b00, "A masks in trace");
    chk(comp_b_mask_eff === 2'b00, "B masks dual trace");
    wr(A_TWO, 8'h48);
    chk(comp_b_mask_eff === 2'b11, "B masks address-data trace");
    chk(addr_data_mode === 1'b0, "mode bit live in trace");
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(A_TRACE, 8'h03);
    hit(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(A_TRACE, 8'h07);
    rd_chk(A_TWO, 8'h40, 1'b0);
    wr(A_TRACE, 8'h00);
    wr(A_STAT, 8'h03);
    $display("test trace done");
  endtask

  // Watchdog
  initial begin
    #400000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {comp_a_match, comp_b_match, comp_c_match, bus_read} = 4'h0;
    {tag_execute, tag_discard, slow} = 3'b000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pair();
    t_dest();
    t_third();
    t_trace();
    complete_run();
  end
endmodule
